// ===== design/i2c_link_engine.sv
/*
 * Bit engine on the link clock: START, STOP, byte out, byte in.
 * Assumes the command fields stay stable while a request toggle is open.
 */
`timescale 1ns/1ps
module i2c_link_engine (
    input wire logic link_clk,
    input wire logic link_rst,
    input wire logic req_tgl,
    input wire i2c_seq_pkg::link_op_e cmd_op,
    input wire logic [7:0] cmd_data,
    input wire logic cmd_nack,
    input wire logic sda_pin,
    output logic done_tgl,
    output logic bit1_tgl,
    output logic [7:0] rx_byte,
    output logic ack_seen,
    output logic scl_oe,
    output logic sda_oe,
    output logic pin_low
);
    import i2c_seq_pkg::*;

    typedef enum {L_IDLE, L_START, L_STOP, L_BITS} lstate_e;
    lstate_e st_q;
    logic [1:0] sync_q;
    logic seen_q;
    logic [1:0] ph_q;
    logic [3:0] bit_q;
    logic [7:0] sh_q;
    logic rd_q;

    i2c_sync2 #(.WIDTH(2)) u_sync (
        .clk(link_clk),
        .rst(link_rst),
        .d({req_tgl, sda_pin}),
        .q(sync_q)
    );

    // open-drain drivers only ever pull low
    always_ff @(posedge link_clk) begin
        pin_low <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // phase machine: four link cycles per bit or condition
    always_ff @(posedge link_clk) begin
        if (link_rst) begin
            st_q <= L_IDLE;
            seen_q <= 1'b0;
            done_tgl <= 1'b0;
            bit1_tgl <= 1'b0;
            ph_q <= 2'd0;
            bit_q <= 4'd0;
            sh_q <= DATA_RST;
            rd_q <= 1'b0;
            rx_byte <= DATA_RST;
            ack_seen <= 1'b0;
            scl_oe <= 1'b0;
            sda_oe <= 1'b0;
        end else begin
            ph_q <= ph_q + 2'd1;
            case (st_q)
                L_IDLE: begin
                    ph_q <= 2'd0;
                    bit_q <= 4'd0;
                    if (sync_q[1] != seen_q) begin
                        seen_q <= sync_q[1];
                        sh_q <= cmd_data;
                        rd_q <= (cmd_op == OP_READ);
                        case (cmd_op)
                            OP_START: st_q <= L_START;
                            OP_STOP: st_q <= L_STOP;
                            default: st_q <= L_BITS;
                        endcase
                    end
                end
                L_START: begin
                    // data released, clock released, then data falls under clock high
                    case (ph_q)
                        2'd0: sda_oe <= 1'b0;
                        PH_HIGH: scl_oe <= 1'b0;
                        PH_SAMPLE: sda_oe <= 1'b1;
                        default: begin
                            scl_oe <= 1'b1;
                            st_q <= L_IDLE;
                            done_tgl <= seen_q;
                        end
                    endcase
                end
                L_STOP: begin
                    // data held low, clock released, then data rises
                    case (ph_q)
                        2'd0: sda_oe <= 1'b1;
                        PH_HIGH: scl_oe <= 1'b0;
                        PH_SAMPLE: sda_oe <= 1'b0;
                        default: begin
                            st_q <= L_IDLE;
                            done_tgl <= seen_q;
                        end
                    endcase
                end
                L_BITS: begin
                    case (ph_q)
                        2'd0: begin
                            if (bit_q == ACK_SLOT) begin
                                // read answers nack when asked, else ack
                                sda_oe <= rd_q & ~cmd_nack;
                            end else begin
                                sda_oe <= ~rd_q & ~sh_q[7];
                            end
                        end
                        PH_HIGH: scl_oe <= 1'b0;
                        PH_SAMPLE: begin
                            // nothing yet: the wire level lags two edges
                            // in the synchroniser, so it is taken at ph 3
                        end
                        default: begin
                            // sync_q now holds the level from the ph 1 edge
                            if (bit_q == ACK_SLOT) begin
                                ack_seen <= ~sync_q[0];
                            end else begin
                                sh_q <= {sh_q[6:0], sync_q[0]};
                            end
                            scl_oe <= 1'b1;
                            bit_q <= bit_q + 4'd1;
                            if (bit_q == 4'd0 && !rd_q) begin
                                bit1_tgl <= ~bit1_tgl;
                            end
                            if (bit_q == ACK_SLOT) begin
                                rx_byte <= sh_q;
                                st_q <= L_IDLE;
                                done_tgl <= seen_q;
                            end
                        end
                    endcase
                end
                default: st_q <= L_IDLE;
            endcase
        end
    end

    chk_start_edge: assert property (@(posedge link_clk) disable iff (link_rst)
        st_q == L_START && ph_q == PH_SAMPLE |=> sda_oe && !scl_oe)
        else $error("start not formed under high clock");
endmodule // i2c_link_engine

// ===== design/i2c_master_transfer_sequencer.sv
/*
 * Master transfer sequencer: software flags, data register, interrupt,
 * and crossing to the link-clock bit engine that drives the two wires.
 * Assumes LINK_CLK runs free and the wire level is resolved outside.
 */
`timescale 1ns/1ps
module i2c_master_transfer_sequencer (
    input wire logic SYS_CLK,
    input wire logic SRST,
    input wire logic LINK_CLK,
    input wire logic CONTROLLER_ON,
    input wire logic TX_IRQ_ENABLE,
    input wire logic NACK_SEND,
    input wire logic START_SET,
    input wire logic STOP_SET,
    input wire logic FLUSH_SET,
    input wire logic DATA_WR,
    input wire logic [7:0] DATA_IN,
    input wire logic DATA_RD,
    input wire logic SDA_IN,
    output logic [7:0] DATA_OUT,
    output logic TX_EMPTY_FLAG,
    output logic RX_FULL_FLAG,
    output logic ACK_FLAG,
    output logic NACK_IRQ_FLAG,
    output logic START_PENDING,
    output logic STOP_PENDING,
    output logic TEN_BIT_ADDR,
    output logic BUS_ACTIVE,
    output logic IRQ,
    output logic SCL_OUT,
    output logic SCL_OE,
    output logic SDA_OUT,
    output logic SDA_OE
);
    import i2c_seq_pkg::*;

    typedef enum {S_IDLE, S_WAIT} sstate_e;

    sstate_e st_q;
    logic link_rst;
    logic req_tgl_q;
    link_op_e op_q;
    logic [7:0] cmd_data_q;
    logic cmd_nack_q;
    logic first_q;
    logic read_mode_q;
    logic addr_byte_q;
    logic [1:0] back_q;
    logic bit1_last_q;
    logic done_tgl;
    logic bit1_tgl;
    logic [7:0] rx_byte;
    logic ack_seen;
    logic pin_low;
    logic done_ev;
    logic bit1_ev;
    logic issue_start;
    logic issue_stop;
    logic issue_write;
    logic issue_read;

    // is this the leading byte of a 10-bit address
    function automatic logic is_ten_bit(input logic [7:0] b);
        return b[7:3] == TEN_BIT_PREFIX;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // reset and events cross into the link domain by two flops each way
    i2c_sync2 #(.WIDTH(1)) u_rst_sync (
        .clk(LINK_CLK),
        .rst(1'b0),
        .d(SRST),
        .q(link_rst)
    );

    i2c_sync2 #(.WIDTH(2)) u_back_sync (
        .clk(SYS_CLK),
        .rst(SRST),
        .d({done_tgl, bit1_tgl}),
        .q(back_q)
    );

    i2c_link_engine u_engine (
        .link_clk(LINK_CLK),
        .link_rst(link_rst),
        .req_tgl(req_tgl_q),
        .cmd_op(op_q),
        .cmd_data(cmd_data_q),
        .cmd_nack(cmd_nack_q),
        .sda_pin(SDA_IN),
        .done_tgl(done_tgl),
        .bit1_tgl(bit1_tgl),
        .rx_byte(rx_byte),
        .ack_seen(ack_seen),
        .scl_oe(SCL_OE),
        .sda_oe(SDA_OE),
        .pin_low(pin_low)
    );

    // both wires are open drain: the driven level is always low
    assign SCL_OUT = pin_low;
    assign SDA_OUT = pin_low;

    ////////////////////////////////////////////////////////////////////////
    // decode of what the sequencer may hand to the engine this cycle
    always_comb begin
        done_ev = (st_q == S_WAIT) && (back_q[1] == req_tgl_q);
        bit1_ev = back_q[0] != bit1_last_q;
        issue_start = 1'b0;
        issue_stop = 1'b0;
        issue_write = 1'b0;
        issue_read = 1'b0;
        if (st_q == S_IDLE && CONTROLLER_ON) begin
            if (START_PENDING) begin
                issue_start = 1'b1;
            end else if (STOP_PENDING) begin
                issue_stop = 1'b1;
            end else if (BUS_ACTIVE && !NACK_IRQ_FLAG) begin
                // read mode pulls bytes only once the last one was taken
                issue_read = read_mode_q && !RX_FULL_FLAG;
                issue_write = !read_mode_q && !TX_EMPTY_FLAG;
            end
        end
    end

    // command handshake: fields held still while the toggle is open
    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            st_q <= S_IDLE;
            req_tgl_q <= 1'b0;
            op_q <= OP_START;
            cmd_data_q <= DATA_RST;
            cmd_nack_q <= 1'b0;
            bit1_last_q <= 1'b0;
        end else begin
            bit1_last_q <= back_q[0];
            if (issue_start || issue_stop || issue_write || issue_read) begin
                st_q <= S_WAIT;
                req_tgl_q <= ~req_tgl_q;
                cmd_data_q <= DATA_OUT;
                cmd_nack_q <= NACK_SEND;
                if (issue_start) begin
                    op_q <= OP_START;
                end else if (issue_stop) begin
                    op_q <= OP_STOP;
                end else if (issue_read) begin
                    op_q <= OP_READ;
                end else begin
                    op_q <= OP_WRITE;
                end
            end else if (done_ev) begin
                st_q <= S_IDLE;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // start and stop requests; a new request wins over the clear on done
    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            START_PENDING <= 1'b0;
            STOP_PENDING <= 1'b0;
        end else begin
            if (START_SET) begin
                START_PENDING <= 1'b1;
            end else if (done_ev && op_q == OP_START) begin
                START_PENDING <= 1'b0;
            end
            if (STOP_SET) begin
                STOP_PENDING <= 1'b1;
            end else if (done_ev && op_q == OP_STOP) begin
                STOP_PENDING <= 1'b0;
            end
        end
    end

    // transfer context: bus ownership, first byte, read direction
    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            BUS_ACTIVE <= 1'b0;
            first_q <= 1'b0;
            read_mode_q <= 1'b0;
            addr_byte_q <= 1'b0;
            TEN_BIT_ADDR <= 1'b0;
        end else if (done_ev) begin
            case (op_q)
                OP_START: begin
                    BUS_ACTIVE <= 1'b1;
                    first_q <= 1'b1;
                    read_mode_q <= 1'b0;
                end
                OP_STOP: begin
                    BUS_ACTIVE <= 1'b0;
                    read_mode_q <= 1'b0;
                end
                OP_WRITE: begin
                    first_q <= 1'b0;
                    addr_byte_q <= first_q;
                    if (first_q) begin
                        TEN_BIT_ADDR <= is_ten_bit(cmd_data_q);
                        // acked address with direction set turns bus to read
                        read_mode_q <= cmd_data_q[0] & ack_seen;
                    end
                end
                default: first_q <= 1'b0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // data register and transmit-empty flag; engine event wins over write
    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            DATA_OUT <= DATA_RST;
            TX_EMPTY_FLAG <= TX_EMPTY_RST;
        end else begin
            if (done_ev && op_q == OP_READ) begin
                DATA_OUT <= rx_byte;
            end else if (DATA_WR && !read_mode_q) begin
                DATA_OUT <= DATA_IN;
            end
            // empty again once the first bit of a byte has left
            if (bit1_ev || FLUSH_SET) begin
                TX_EMPTY_FLAG <= 1'b1;
            end else if (DATA_WR && !read_mode_q) begin
                TX_EMPTY_FLAG <= 1'b0;
            end
        end
    end

    // receive-full: a fresh byte wins over a clearing read
    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            RX_FULL_FLAG <= 1'b0;
        end else if (done_ev && op_q == OP_READ) begin
            RX_FULL_FLAG <= 1'b1;
        end else if (DATA_RD) begin
            RX_FULL_FLAG <= 1'b0;
        end
    end

    // acknowledge status and nack flag from each written byte
    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            ACK_FLAG <= 1'b0;
            NACK_IRQ_FLAG <= 1'b0;
        end else if (done_ev) begin
            case (op_q)
                OP_WRITE: begin
                    ACK_FLAG <= ack_seen;
                    if (!ack_seen) begin
                        NACK_IRQ_FLAG <= 1'b1;
                    end
                end
                OP_READ: begin
                    // the nacked byte is the last one of the read
                    if (cmd_nack_q) begin
                        NACK_IRQ_FLAG <= 1'b1;
                    end
                end
                OP_STOP: NACK_IRQ_FLAG <= 1'b0;
                default: NACK_IRQ_FLAG <= NACK_IRQ_FLAG;
            endcase
        end
    end

    // single registered interrupt line toward the cpu
    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            IRQ <= 1'b0;
        end else begin
            IRQ <= (TX_IRQ_ENABLE & TX_EMPTY_FLAG)
                | RX_FULL_FLAG | NACK_IRQ_FLAG;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    chk_tx_irq: assert property (@(posedge SYS_CLK) disable iff (SRST)
        TX_IRQ_ENABLE && TX_EMPTY_FLAG |=> IRQ)
        else $error("empty data register did not interrupt");

    chk_bit1_empty: assert property (@(posedge SYS_CLK) disable iff (SRST)
        bit1_ev |=> TX_EMPTY_FLAG)
        else $error("first bit sent without empty flag");

    chk_start_first: assert property (@(posedge SYS_CLK) disable iff (SRST)
        issue_start |-> !issue_write && !issue_read)
        else $error("byte issued alongside start");

    chk_nack_set: assert property (@(posedge SYS_CLK) disable iff (SRST)
        done_ev && op_q == OP_WRITE && !ack_seen |=> NACK_IRQ_FLAG && !ACK_FLAG)
        else $error("missing ack not flagged");

    chk_ack_set: assert property (@(posedge SYS_CLK) disable iff (SRST)
        done_ev && op_q == OP_WRITE && ack_seen |=> ACK_FLAG)
        else $error("ack not recorded");

    chk_stop_clear: assert property (@(posedge SYS_CLK) disable iff (SRST)
        done_ev && op_q == OP_STOP && !STOP_SET
        |=> !STOP_PENDING && !NACK_IRQ_FLAG)
        else $error("stop did not clear its flags");

    chk_rx_full: assert property (@(posedge SYS_CLK) disable iff (SRST)
        done_ev && op_q == OP_READ |=> RX_FULL_FLAG ##1 IRQ)
        else $error("received byte not flagged");

    chk_rx_clear: assert property (@(posedge SYS_CLK) disable iff (SRST)
        DATA_RD && !(done_ev && op_q == OP_READ) |=> !RX_FULL_FLAG)
        else $error("data read left receive flag set");

    chk_last_nack: assert property (@(posedge SYS_CLK) disable iff (SRST)
        done_ev && op_q == OP_READ && cmd_nack_q |=> NACK_IRQ_FLAG)
        else $error("last read byte gave no nack flag");

    chk_same_path: assert property (@(posedge SYS_CLK) disable iff (SRST)
        issue_write |=> op_q == OP_WRITE && cmd_data_q == $past(DATA_OUT))
        else $error("byte not loaded from data register");
endmodule // i2c_master_transfer_sequencer

// ===== design/i2c_seq_pkg.sv
/*
 * Shared constants and types for the two-wire master transfer sequencer.
 * Assumes one system clock domain and one free-running link clock domain.
 */
// Overview of operation
// - 10-bit first address byte is 11110, two top address bits, direction.
// - After both 10-bit address bytes, data moves as with 7-bit addressing.
// - Transmit interrupt asserts whenever data register empty and enabled.
// - Start request makes START, then shift register loads from data.
// - After first address bit leaves, transmit interrupt asserts again.
// - Slave pulling data low after a byte sets the acknowledge bit.
// - Missing acknowledge sets nack flag and clears acknowledge bit.
// - Stop request drives STOP, then clears stop request and nack flag.
// - After second address byte's first bit, transmit interrupt asserts.
// - For reads, address goes out after START with read direction.
// - Each received byte answered nack if send-nack set, else ack.
// - Each received byte sets receive-full flag and raises interrupt.
// - Reading data register clears receive-full; software reads each byte.
// - After the last read byte, nack interrupt flag is raised.
package i2c_seq_pkg;

    // operations handed from the sequencer to the link engine
    typedef enum logic [1:0] {OP_START, OP_STOP, OP_WRITE, OP_READ} link_op_e;

    localparam int BYTE_BITS = 8;
    localparam logic [3:0] ACK_SLOT = 4'd8;
    localparam logic [1:0] PH_LAST = 2'd3;
    localparam logic [1:0] PH_HIGH = 2'd1;
    localparam logic [1:0] PH_SAMPLE = 2'd2;
    localparam logic [4:0] TEN_BIT_PREFIX = 5'b11110;
    localparam logic [7:0] DATA_RST = 8'h00;
    localparam logic TX_EMPTY_RST = 1'b1;

endpackage

// ===== design/i2c_sync2.sv
/*
 * Two-flop level synchroniser, one lane per bit.
 * Assumes each lane is a level or toggle that stays put for two edges.
 */
`timescale 1ns/1ps
module i2c_sync2 #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_q;

    // first stage feeds the second stage only
    always_ff @(posedge clk) begin
        if (rst) begin
            meta_q <= '0;
            q <= '0;
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule // i2c_sync2

// ===== verification/i2c_slave_model.sv
/*
 * Behavioural two-wire slave: acks written bytes, returns counting bytes.
 * Assumes resolved open-drain wire levels with pull-ups on both lines.
 */
`timescale 1ns/1ps
module i2c_slave_model (
    input wire logic scl,
    input wire logic sda,
    input wire logic ack_en,
    input wire logic [7:0] tx_byte,
    output logic sda_oe,
    output logic [7:0] last_rx,
    output logic master_nack,
    output int n_bytes,
    output int n_starts,
    output int n_stops
);
    int bitcnt = 0;
    logic first = 0;
    logic rd = 0;
    logic [7:0] sh = 8'h00;
    logic [7:0] k = 8'h00;
    initial begin
        sda_oe = 0;
        last_rx = 8'h00;
        master_nack = 0;
        n_bytes = 0;
        n_starts = 0;
        n_stops = 0;
    end
    ////////////////////////////////////////////////////////////////////////
    // frame edges: data moving while the clock is high
    always @(negedge sda) begin
        if (scl) begin
            n_starts++;
            bitcnt = 0;
            first = 1;
            rd = 0;
            master_nack = 0;
            sda_oe = 0;
        end
    end
    always @(posedge sda) begin
        if (scl) begin
            n_stops++;
            rd = 0;
        end
    end
    // sample on the rising clock, msb first
    always @(posedge scl) begin
        if (bitcnt < 8 && !rd)
            sh = {sh[6:0], sda};
        if (bitcnt == 7 && !rd) begin
            last_rx = sh;
            n_bytes++;
        end
        if (bitcnt == 8 && rd)
            master_nack = sda;
        bitcnt++;
    end
    // drive only while the clock is low, so no false frame edges
    always @(negedge scl) begin
        if (bitcnt == 8 && !rd)
            sda_oe = ack_en;
        else if (bitcnt == 8)
            sda_oe = 0;
        else if (bitcnt == 9) begin
            bitcnt = 0;
            sda_oe = 0;
            if (first) begin
                rd = sh[0] & ack_en;
                k = 8'h00;
            end
            first = 0;
            // after a master nack the line is let go for the stop
            if (rd && !master_nack) begin
                sh = tx_byte + k;
                k++;
                sda_oe = ~sh[7];
            end
        end else if (rd && bitcnt > 0 && bitcnt < 8)
            sda_oe = ~sh[7 - bitcnt];
    end
endmodule // i2c_slave_model

// ===== verification/testbench.sv
/*
 * Self-checking bench for the master transfer sequencer.
 * Assumes the slave model on the far side and pull-ups on both wires.
 */
`timescale 1ns/1ps
module testbench;
    logic SYS_CLK, SRST, LINK_CLK, CONTROLLER_ON, TX_IRQ_ENABLE, NACK_SEND;
    logic START_SET, STOP_SET, FLUSH_SET, DATA_WR, DATA_RD, SDA_IN;
    logic [7:0] DATA_IN, DATA_OUT, tx_byte, last_rx;
    logic TX_EMPTY_FLAG, RX_FULL_FLAG, ACK_FLAG, NACK_IRQ_FLAG, START_PENDING;
    logic STOP_PENDING, TEN_BIT_ADDR, BUS_ACTIVE, IRQ, SCL_OUT, SCL_OE;
    logic SDA_OUT, SDA_OE, scl, s_oe, ack_en, m_nack;
    logic [31:0] seed = 32'h0000a93a;
    logic [31:0] v;
    int n_bytes, n_starts, n_stops, st, sp;
    int fails = 0;
    int n_compared = 0;
    int cyc = 0;
    localparam logic [4:0] P_START = 5'h10;
    localparam logic [4:0] P_STOP = 5'h08;
    localparam logic [4:0] P_FLUSH = 5'h04;
    localparam logic [4:0] P_WR = 5'h02;
    localparam logic [4:0] P_RD = 5'h01;
    ////////////////////////////////////////////////////////////////////////
    i2c_master_transfer_sequencer uut (.SYS_CLK(SYS_CLK), .SRST(SRST),
        .LINK_CLK(LINK_CLK), .CONTROLLER_ON(CONTROLLER_ON),
        .TX_IRQ_ENABLE(TX_IRQ_ENABLE), .NACK_SEND(NACK_SEND),
        .START_SET(START_SET), .STOP_SET(STOP_SET), .FLUSH_SET(FLUSH_SET),
        .DATA_WR(DATA_WR), .DATA_IN(DATA_IN), .DATA_RD(DATA_RD),
        .SDA_IN(SDA_IN), .DATA_OUT(DATA_OUT), .TX_EMPTY_FLAG(TX_EMPTY_FLAG),
        .RX_FULL_FLAG(RX_FULL_FLAG), .ACK_FLAG(ACK_FLAG),
        .NACK_IRQ_FLAG(NACK_IRQ_FLAG), .START_PENDING(START_PENDING),
        .STOP_PENDING(STOP_PENDING), .TEN_BIT_ADDR(TEN_BIT_ADDR),
        .BUS_ACTIVE(BUS_ACTIVE), .IRQ(IRQ), .SCL_OUT(SCL_OUT),
        .SCL_OE(SCL_OE), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE));
    i2c_slave_model slave (.scl(scl), .sda(SDA_IN), .ack_en(ack_en),
        .tx_byte(tx_byte), .sda_oe(s_oe), .last_rx(last_rx),
        .master_nack(m_nack), .n_bytes(n_bytes), .n_starts(n_starts),
        .n_stops(n_stops));
    // open-drain wires, released lines float high
    assign scl = SCL_OE ? SCL_OUT : 1'b1;
    assign SDA_IN = (SDA_OE ? SDA_OUT : 1'b1) & ~s_oe;
    // clocks, link offset by 3, yet every fifth link rise meets a system rise
    initial begin
        SYS_CLK = 0;
        forever #5 SYS_CLK = ~SYS_CLK;
    end
    initial begin
        LINK_CLK = 0;
        #3;
        forever #32 LINK_CLK = ~LINK_CLK;
    end
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic chk1(input logic seen, input logic exp);
        check({7'h00, seen}, {7'h00, exp});
    endtask
    // one-cycle software pulses, driven on the falling edge
    task automatic pulse(input logic [4:0] m, input logic [7:0] b);
        @(negedge SYS_CLK);
        {START_SET, STOP_SET, FLUSH_SET, DATA_WR, DATA_RD} = m;
        DATA_IN = b;
        @(negedge SYS_CLK);
        {START_SET, STOP_SET, FLUSH_SET, DATA_WR, DATA_RD} = 5'h00;
    endtask
    function automatic logic probe(input int k, input int goal);
        case (k)
            0: return TX_EMPTY_FLAG;
            1: return ACK_FLAG;
            2: return NACK_IRQ_FLAG;
            3: return RX_FULL_FLAG;
            4: return !BUS_ACTIVE;
            default: return n_bytes >= goal;
        endcase
    endfunction
    // bounded wait, a byte takes well under a thousand cycles
    task automatic wait_on(input int k, input int goal);
        for (int i = 0; i < 3000 && probe(k, goal) !== 1'b1; i++)
            @(negedge SYS_CLK);
        if (probe(k, goal) !== 1'b1)
            fails++;
    endtask
    task automatic stop_bus();
        sp = n_stops;
        wait_on(4, 0);
        check(8'(n_stops - sp), 8'h01);
        chk1(STOP_PENDING, 1'b0);
        chk1(NACK_IRQ_FLAG, 1'b0);
    endtask
    task automatic ten_bit_write(input logic [9:0] a, input logic [7:0] d);
        int base;
        base = n_bytes;
        st = n_starts;
        pulse(P_WR, {4'hf, 1'h0, a[9:8], 1'h0});
        chk1(TX_EMPTY_FLAG, 1'b0);
        pulse(P_START, 8'h00);
        chk1(START_PENDING, 1'b1);
        wait_on(0, 0);
        chk1(START_PENDING, 1'b0);
        check(8'(n_starts - st), 8'h01);
        @(negedge SYS_CLK);
        chk1(IRQ, 1'b1);
        pulse(P_WR, a[7:0]);
        wait_on(0, 0);
        check(last_rx, {4'hf, 1'h0, a[9:8], 1'h0});
        chk1(ACK_FLAG, 1'b1);
        chk1(TEN_BIT_ADDR, 1'b1);
        @(negedge SYS_CLK);
        chk1(IRQ, 1'b1);
        pulse(P_WR, d);
        wait_on(5, base + 2);
        check(last_rx, a[7:0]);
        wait_on(5, base + 3);
        check(last_rx, d);
        pulse(P_STOP, 8'h00);
        stop_bus();
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // hang guard, the whole run needs a few thousand cycles
    always @(posedge SYS_CLK) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fails++;
            tally_and_finish();
        end
    end
    initial begin
        {SRST, CONTROLLER_ON, TX_IRQ_ENABLE, NACK_SEND} = 4'h8;
        {START_SET, STOP_SET, FLUSH_SET, DATA_WR, DATA_RD} = 5'h00;
        DATA_IN = 8'h00;
        ack_en = 1;
        tx_byte = 8'h00;
        repeat (20) @(negedge SYS_CLK);
        SRST = 0;
        repeat (40) @(negedge SYS_CLK);
        chk1(TX_EMPTY_FLAG, 1'b1);
        chk1(IRQ, 1'b0);
        CONTROLLER_ON = 1;
        @(negedge SYS_CLK);
        TX_IRQ_ENABLE = 1;
        repeat (2) @(negedge SYS_CLK);
        chk1(IRQ, 1'b1);
        ten_bit_write(10'h3ff, 8'h00);
        v = xs();
        ten_bit_write(v[9:0], v[17:10]);
        // unanswered address, write then read: abort with stop
        ack_en = 0;
        v = xs();
        for (int dir = 0; dir < 2; dir++) begin
            pulse(P_WR, {v[6:0], dir[0]});
            pulse(P_START, 8'h00);
            wait_on(2, 0);
            chk1(ACK_FLAG, 1'b0);
            chk1(NACK_IRQ_FLAG, 1'b1);
            TX_IRQ_ENABLE = 0;
            // a stray byte left behind is dropped only by the flush
            pulse(P_WR, 8'h00);
            pulse(dir ? P_STOP : P_STOP | P_FLUSH, 8'h00);
            stop_bus();
            chk1(TX_EMPTY_FLAG, dir == 0);
        end
        // two-byte read, last byte refused by the master
        ack_en = 1;
        tx_byte = v[15:8];
        pulse(P_WR, {v[6:0], 1'h1});
        pulse(P_START, 8'h00);
        wait_on(3, 0);
        check(DATA_OUT, v[15:8]);
        @(negedge SYS_CLK);
        chk1(IRQ, 1'b1);
        chk1(m_nack, 1'b0);
        NACK_SEND = 1;
        pulse(P_RD, 8'h00);
        chk1(RX_FULL_FLAG, 1'b0);
        wait_on(3, 0);
        check(DATA_OUT, v[15:8] + 8'h01);
        wait_on(2, 0);
        chk1(NACK_IRQ_FLAG, 1'b1);
        chk1(m_nack, 1'b1);
        pulse(P_RD, 8'h00);
        pulse(P_STOP, 8'h00);
        stop_bus();
        tally_and_finish();
    end
endmodule // testbench
